// ===== common/vmx_pkg.sv
package vmx_pkg;

  // slave address: fixed low bits, strap pins fill the top two
  localparam logic [7:0] VMX_BASE_ADDR    = 8'h06;
  localparam int         VMX_STRAP_HI_BIT = 7;
  localparam int         VMX_STRAP_LO_BIT = 6;

  // register offsets and register count
  localparam logic [7:0] VMX_REG_SEL12 = 8'h00;
  localparam logic [7:0] VMX_REG_SEL34 = 8'h01;
  localparam logic [7:0] VMX_REG_SEL56 = 8'h02;
  localparam logic [7:0] VMX_REG_CLAMP = 8'h03;
  localparam logic [7:0] VMX_REG_GAIN  = 8'h04;
  localparam logic [7:0] VMX_REG_COUNT = 8'h05;

  // values after reset and field layout
  localparam logic [7:0] VMX_REG_RESET = 8'h00;
  localparam logic [3:0] VMX_SEL_OFF   = 4'h0;
  localparam logic [3:0] VMX_SEL_MAX   = 4'h8;
  localparam int         VMX_SEL_LO    = 0;
  localparam int         VMX_SEL_HI    = 4;
  localparam int         VMX_NUM_IN    = 8;
  localparam int         VMX_NUM_OUT   = 6;
  localparam int         VMX_NUM_PAIRS = 3;

  // bit counter value of the last bit of a byte
  localparam logic [2:0] VMX_LAST_BIT = 3'h7;

  // receiver states and byte kinds
  typedef enum logic [1:0] {
    VMX_ST_IDLE,
    VMX_ST_RECV,
    VMX_ST_ACK,
    VMX_ST_IGNORE
  } vmx_state_e;

  typedef enum logic [1:0] {
    VMX_PH_ADDR,
    VMX_PH_PTR,
    VMX_PH_DATA
  } vmx_phase_e;

  // control outputs toward the analog matrix
  typedef struct packed {
    logic [VMX_NUM_OUT-1:0][3:0]            sel;
    logic [VMX_NUM_OUT-1:0][VMX_NUM_IN-1:0] src;
    logic [VMX_NUM_OUT-1:0]                 pdn;
    logic [VMX_NUM_IN-1:0]                  input_level_mode;
    logic [VMX_NUM_OUT-1:0]                 output_amp_level;
  } vmx_ctrl_s;

  // open-drain data line
  typedef struct packed {
    logic o;
    logic oe;
  } vmx_od_s;

endpackage : vmx_pkg

// ===== dv/video_matrix_i2c_control_tb_top.sv
`timescale 1ns/1ps

module video_matrix_i2c_control_tb_top;
  import vmx_pkg::*;
  logic      clk;
  logic      arst_n;
  logic      scl;
  logic      m_pull;
  logic      sda_drive;
  logic      sda_oe;
  logic      bus_busy;
  logic      slave_id_strap_bit6;
  logic      slave_id_strap_bit7;
  wire       sda_w;
  vmx_ctrl_s ctrl;
  logic [7:0] regs [5];
  int        bad_count;
  int        num_checks;

  // open-drain wire: either party pulls low
  assign sda_w = (sda_oe ? sda_drive : 1'b1) & ~m_pull;

  vmx_ctrl DUT (.clk(clk), .arst_n(arst_n), .scl(scl), .sda(sda_w),
    .sda_drive(sda_drive), .sda_oe(sda_oe), .slave_id_strap_bit6(slave_id_strap_bit6),
    .slave_id_strap_bit7(slave_id_strap_bit7), .ctrl(ctrl), .bus_busy(bus_busy));
  vmx_i2c_master mst (.clk(clk), .sda(sda_w), .scl(scl), .sda_pull(m_pull));

  // clock generator
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // expected control outputs from the register image
  function automatic vmx_ctrl_s exp_ctrl();
    vmx_ctrl_s e;
    logic [3:0] s;
    e = '0;
    for (int n = 0; n < VMX_NUM_OUT; n++) begin
      s = n[0] ? regs[n/2][7:4] : regs[n/2][3:0];
      e.sel[n] = s;
      e.pdn[n] = (s == 4'h0);
      if (s != 4'h0 && s <= 4'h8) e.src[n] = 8'h01 << (s - 4'h1);
    end
    e.input_level_mode = regs[3];
    e.output_amp_level = regs[4][5:0];
    return e;
  endfunction : exp_ctrl

  function automatic logic [7:0] dev(input logic [1:0] st);
    return {st, VMX_BASE_ADDR[5:0]};
  endfunction : dev

  task automatic wr(input string w, input logic [7:0] q[$], input logic ds,
                    input logic [7:0] ea);
    logic [7:0] acks;
    logic       clash;
    mst.xfer(q, ds, acks, clash);
    chk({w, " acks"}, ea, acks);
    chk({w, " sda"}, 1'b0, clash);
    chk({w, " ctrl"}, exp_ctrl(), ctrl);
  endtask : wr

  task automatic t_reset();
    chk("rst ctrl", exp_ctrl(), ctrl);
    chk("rst oe", 1'b0, sda_oe);
    chk("rst busy", 1'b0, bus_busy);
    $display("test reset done");
  endtask : t_reset

  task automatic t_strap();
    logic [7:0] a;
    logic [7:0] g;
    for (int st = 0; st < 4; st++) begin
      @(negedge clk);
      slave_id_strap_bit7 = st[1];
      slave_id_strap_bit6 = st[0];
      repeat (4) @(negedge clk);
      a = dev(st[1:0]);
      g = {2'b11, st[1:0], 4'h9};
      wr("foreign", '{a ^ 8'h40, VMX_REG_GAIN, 8'h3F}, 1'b1, 8'h00);
      wr("read", '{a | 8'h01, VMX_REG_GAIN, 8'h3F}, 1'b1, 8'h00);
      regs[4] = g;
      wr("own", '{a, VMX_REG_GAIN, g}, 1'b1, 8'h07);
    end
    slave_id_strap_bit7 = 1'b0;
    slave_id_strap_bit6 = 1'b0;
    repeat (4) @(negedge clk);
    $display("test strap done");
  endtask : t_strap

  task automatic t_route();
    regs[0] = 8'h21;
    regs[1] = 8'h13;
    regs[2] = 8'h80;
    regs[3] = 8'hA5;
    regs[4] = 8'hFF;
    wr("route", '{dev(2'b00), VMX_REG_SEL12, 8'h21, 8'h13, 8'h80, 8'hA5, 8'hFF},
       1'b1, 8'h7F);
    $display("test route done");
  endtask : t_route

  task automatic t_unmapped();
    regs[4] = 8'h00;
    wr("unmap", '{dev(2'b00), VMX_REG_GAIN, 8'h00, 8'hFF, 8'hEE}, 1'b1, 8'h1F);
    wr("alias", '{dev(2'b00), 8'h08, 8'h55}, 1'b1, 8'h07);
    regs[2] = 8'h9F;
    wr("oor sel", '{dev(2'b00), VMX_REG_SEL56, 8'h9F}, 1'b1, 8'h07);
    $display("test unmapped done");
  endtask : t_unmapped

  task automatic t_restart();
    wr("part", '{dev(2'b00), VMX_REG_SEL12}, 1'b0, 8'h03);
    chk("busy mid", 1'b1, bus_busy);
    regs[2] = 8'h00;
    wr("restart", '{dev(2'b00), VMX_REG_SEL56, 8'h00}, 1'b1, 8'h07);
    chk("busy end", 1'b0, bus_busy);
    $display("test restart done");
  endtask : t_restart

  // reset in mid-run clears every field
  task automatic t_rereset();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (6) @(negedge clk);
    chk("rerst ctrl", exp_ctrl(), ctrl);
    chk("rerst busy", 1'b0, bus_busy);
    regs[3] = 8'h5A;
    wr("post rst", '{dev(2'b00), VMX_REG_CLAMP, 8'h5A}, 1'b1, 8'h07);
    $display("test rereset done");
  endtask : t_rereset

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    bad_count  = 0;
    num_checks = 0;
    foreach (regs[i]) regs[i] = 8'h00;
    arst_n = 1'b0;
    slave_id_strap_bit6 = 1'b0;
    slave_id_strap_bit7 = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_strap();
    t_route();
    t_unmapped();
    t_restart();
    t_rereset();
    test_done();
  end
endmodule : video_matrix_i2c_control_tb_top

// ===== dv/vmx_i2c_master.sv
`timescale 1ns/1ps

// behavioural bus master: drives scl, pulls sda low
module vmx_i2c_master (
  // sampling clock
  input  wire logic clk,
  // resolved data line
  input  wire logic sda,
  // bus outputs
  output logic      scl,
  output logic      sda_pull
);
  // idle bus, both lines released
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // wait n falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic start();
    tick(1);
    sda_pull = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask : start

  // stop: data rises, clock high
  task automatic stop();
    tick(1);
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask : stop

  // fixed clock, four clocks per half period
  // msb first, data moves while clock low
  task automatic send(input logic [7:0] b, output logic ack, output logic clash);
    logic a0;
    clash = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      tick(1);
      sda_pull = (i > 0) ? ~b[i-1] : 1'b0;
      tick(3);
      scl = 1'b1;
      tick(1);
      a0 = sda;
      tick(3);
      // ack held low, data bits untouched
      if (i > 0 && (a0 !== b[i-1] || sda !== b[i-1])) clash = 1'b1;
      ack = (a0 === 1'b0 && sda === 1'b0);
      scl = 1'b0;
    end
  endtask : send

  // address first, any number of bytes
  task automatic xfer(input logic [7:0] q[$], input logic do_stop,
                      output logic [7:0] acks, output logic clash);
    logic a;
    logic c;
    acks  = 8'h00;
    clash = 1'b0;
    start();
    foreach (q[k]) begin
      send(q[k], a, c);
      acks[k] = a;
      clash   = clash | c;
    end
    if (do_stop) stop();
  endtask : xfer
endmodule : vmx_i2c_master

// ===== src/vmx_ctrl.sv
`timescale 1ns/1ps

// Functional notes
// (RL1) base slave address 0x06, offset by straps
// (RL2) upper strap sets bit 7, lower bit 6
// (RL3) write: address, register pointer, data byte
// (RL4) pair registers: low nibble odd, high even
// (RL5) zero means off, 1 to 8 pick inputs
// (RL6) off selection powers the output down
// (RL7) many outputs may share one input
// (RL8) clamp register: 1 clamp, 0 bias per input
// (RL9) gain register: 0 is 6dB, 1 is 0dB
// (RL10) all control fields clear after reset
// (RL11) unmapped writes acknowledged, change nothing
// (RL12) write only, data line never carries data
// (RL13) data change during clock high is control
// (RL14) start: data falls while clock high, restart
// (RL15) stop: data rises while clock high, idle
// (RL16) hold data low through ninth clock high
// (RL17) first byte after start is the address
// (RL18) master starts only on an idle bus
// (RL19) master clocks at standard rate, 100 kHz; testbench master runs at 3.125 MHz (8 clk periods of 40 ns)
// (RL20) unlimited data bytes, each one acknowledged
// (RL21) address mismatch: no acknowledge, wait start
// (RL22) each data byte writes, pointer then advances
// (RL23) register updates when acknowledge clock ends
module vmx_ctrl
  import vmx_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // two-wire bus pins
  input  wire logic              scl,
  input  wire logic              sda,
  output logic                   sda_drive,
  output logic                   sda_oe,
  // address straps
  input  wire logic              slave_id_strap_bit6,
  input  wire logic              slave_id_strap_bit7,
  // control toward the analog matrix
  output vmx_pkg::vmx_ctrl_s     ctrl,
  // receiver status
  output logic                   bus_busy
);

  // one-hot source decode of a selection field
  function automatic logic [VMX_NUM_IN-1:0] sel_onehot(input logic [3:0] s);
    logic [VMX_NUM_IN-1:0] oh;
    oh = '0;
    if (s != VMX_SEL_OFF && s <= VMX_SEL_MAX) begin
      oh = VMX_NUM_IN'(1) << (s - 4'h1);
    end
    return oh;
  endfunction : sel_onehot

  logic [3:0]                 pins_s;
  logic                       scl_s;
  logic                       sda_s;
  logic                       scl_q;
  logic                       sda_q;
  logic                       strap6_s;
  logic                       strap7_s;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_det;
  logic                       stop_det;
  vmx_state_e                 state_r;
  vmx_phase_e                 phase_r;
  logic [2:0]                 bit_cnt_r;
  logic                       byte_done_r;
  logic [7:0]                 shift_r;
  logic [7:0]                 ptr_r;
  logic [VMX_REG_COUNT-1:0][7:0] regs_r;
  vmx_od_s                    od_r;
  logic [7:0]                 my_addr;
  logic                       addr_hit;
  logic                       byte_end;
  logic                       ack_end;
  logic                       wr_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // pins cross into the clock domain
  vmx_sync #(
    .W (4)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({slave_id_strap_bit7, slave_id_strap_bit6, sda, scl}),
    .q      (pins_s)
  );

  assign scl_s    = pins_s[0];
  assign sda_s    = pins_s[1];
  assign strap6_s = pins_s[2];
  assign strap7_s = pins_s[3];

  // previous line levels for edge finding
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // clock edges and bus conditions
  // (RL13) control while clock high
  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = scl_s & scl_q & ~sda_q & sda_s;

  // own address from base value and straps
  // (RL1) base plus strap offset
  // (RL2) straps on bits 7 and 6
  always_comb begin
    my_addr                   = VMX_BASE_ADDR;
    my_addr[VMX_STRAP_HI_BIT] = strap7_s;
    my_addr[VMX_STRAP_LO_BIT] = strap6_s;
  end

  // byte and acknowledge boundaries
  assign addr_hit = (shift_r == my_addr);
  assign byte_end = (state_r == VMX_ST_RECV) && byte_done_r && scl_fall;
  assign ack_end  = (state_r == VMX_ST_ACK) && scl_fall;
  assign wr_en    = ack_end && (phase_r == VMX_PH_DATA) && (ptr_r < VMX_REG_COUNT);

  // receiver state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= VMX_ST_IDLE;
    end else if (start_det) begin
      // (RL14) start restarts reception
      state_r <= VMX_ST_RECV;
    end else if (stop_det) begin
      // (RL15) stop returns to idle
      state_r <= VMX_ST_IDLE;
    end else begin
      case (state_r)
        VMX_ST_RECV: begin
          if (byte_end) begin
            // (RL21) foreign address ignored
            if (phase_r == VMX_PH_ADDR && !addr_hit) begin
              state_r <= VMX_ST_IGNORE;
            end else begin
              state_r <= VMX_ST_ACK;
            end
          end
        end
        VMX_ST_ACK: begin
          if (ack_end) begin
            state_r <= VMX_ST_RECV;
          end
        end
        VMX_ST_IDLE:   state_r <= VMX_ST_IDLE;
        VMX_ST_IGNORE: state_r <= VMX_ST_IGNORE;
        default:       state_r <= VMX_ST_IDLE;
      endcase
    end
  end

  // bit counter and shift register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r   <= 3'h0;
      byte_done_r <= 1'b0;
      shift_r     <= 8'h00;
    end else if (start_det || stop_det || ack_end) begin
      bit_cnt_r   <= 3'h0;
      byte_done_r <= 1'b0;
    end else if (state_r == VMX_ST_RECV && scl_rise) begin
      // bits arrive msb first, sampled at clock rise
      shift_r     <= {shift_r[6:0], sda_s};
      bit_cnt_r   <= bit_cnt_r + 3'h1;
      byte_done_r <= (bit_cnt_r == VMX_LAST_BIT);
    end
  end

  // byte kind within the transfer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= VMX_PH_ADDR;
    end else if (start_det) begin
      // (RL17) first byte is the address
      phase_r <= VMX_PH_ADDR;
    end else if (ack_end) begin
      // (RL3) address, pointer, then data
      case (phase_r)
        VMX_PH_ADDR: phase_r <= VMX_PH_PTR;
        VMX_PH_PTR:  phase_r <= VMX_PH_DATA;
        VMX_PH_DATA: phase_r <= VMX_PH_DATA;
        default:     phase_r <= VMX_PH_ADDR;
      endcase
    end
  end

  // register pointer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= 8'h00;
    end else if (ack_end && phase_r == VMX_PH_PTR) begin
      ptr_r <= shift_r;
    end else if (ack_end && phase_r == VMX_PH_DATA) begin
      // (RL22) advance after each data byte
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // control registers
  // (RL10) all fields clear at reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regs_r <= {VMX_REG_COUNT{VMX_REG_RESET}};
    end else if (wr_en) begin
      // (RL23) commit at end of acknowledge clock
      // (RL11) unmapped pointers never reach here
      regs_r[ptr_r[2:0]] <= shift_r;
    end
  end

  // acknowledge drive on the data line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      od_r <= '0;
    end else if (start_det || stop_det || ack_end) begin
      od_r <= '0;
    end else if (byte_end && !(phase_r == VMX_PH_ADDR && !addr_hit)) begin
      // (RL16) pull low through ninth pulse
      // (RL20) every byte after address acked
      od_r.oe <= 1'b1;
    end
  end

  // (RL12) only ever drives a low acknowledge
  assign sda_drive = od_r.o;
  assign sda_oe   = od_r.oe;
  assign bus_busy = (state_r != VMX_ST_IDLE);

  // register fields mapped onto the matrix controls
  always_comb begin
    ctrl = '0;
    for (int k = 0; k < VMX_NUM_PAIRS; k++) begin
      // (RL4) low nibble odd output, high nibble even
      ctrl.sel[2*k]   = regs_r[k][VMX_SEL_LO +: 4];
      ctrl.sel[2*k+1] = regs_r[k][VMX_SEL_HI +: 4];
    end
    for (int n = 0; n < VMX_NUM_OUT; n++) begin
      // (RL5) binary input number, zero is off
      // (RL7) each output decoded independently
      ctrl.src[n] = sel_onehot(ctrl.sel[n]);
      // (RL6) off selection powers down
      ctrl.pdn[n] = (ctrl.sel[n] == VMX_SEL_OFF);
    end
    // (RL8) clamp or bias per input
    ctrl.input_level_mode = regs_r[VMX_REG_CLAMP[2:0]];
    // (RL9) gain per output, top bits unused
    ctrl.output_amp_level = regs_r[VMX_REG_GAIN[2:0]][VMX_NUM_OUT-1:0];
  end

  // checks on address handling
  // (RL21) mismatch gets no acknowledge
  chk_addr_nack: assert property ( // (RL21)
    byte_end && phase_r == VMX_PH_ADDR && !addr_hit
    |=> !sda_oe && state_r == VMX_ST_IGNORE)
    else $error("foreign address acknowledged");

  // (RL17) matching address acknowledged
  chk_addr_ack: assert property ( // (RL17)
    byte_end && phase_r == VMX_PH_ADDR && addr_hit |=> sda_oe)
    else $error("own address not acknowledged");

  // (RL2) only the strap-built address is acknowledged
  chk_strap_map: assert property ( // (RL2)
    byte_end && phase_r == VMX_PH_ADDR
    && shift_r != {strap7_s, strap6_s, VMX_BASE_ADDR[5:0]} |=> !sda_oe)
    else $error("address ignoring straps acknowledged");

  // checks on the acknowledge
  // (RL16) low held until clock falls
  chk_ack_hold: assert property ( // (RL16)
    sda_oe && !scl_fall && !start_det && !stop_det |=> sda_oe)
    else $error("acknowledge released early");

  // (RL12) drive only in acknowledge slot
  chk_only_ack: assert property ( // (RL12)
    sda_oe |-> state_r == VMX_ST_ACK && sda_drive == 1'b0)
    else $error("data line driven outside acknowledge");

  // (RL20) data bytes always acknowledged
  chk_data_ack: assert property ( // (RL20)
    byte_end && phase_r != VMX_PH_ADDR |=> sda_oe ##0 state_r == VMX_ST_ACK)
    else $error("data byte not acknowledged");

  // checks on bus conditions
  // (RL14) start restarts from address byte
  chk_start_rst: assert property ( // (RL14)
    start_det |=> state_r == VMX_ST_RECV && bit_cnt_r == 3'h0
                  && phase_r == VMX_PH_ADDR && !sda_oe)
    else $error("start did not restart reception");

  // (RL15) stop goes idle
  chk_stop_idle: assert property ( // (RL15)
    stop_det |=> state_r == VMX_ST_IDLE && !sda_oe && !bus_busy)
    else $error("stop did not return to idle");

  // checks on register writes
  // (RL23) data lands at the pointed register
  chk_reg_write: assert property ( // (RL23)
    wr_en |=> regs_r[$past(ptr_r[2:0])] == $past(shift_r))
    else $error("data byte not stored");

  // (RL22) pointer moves by one per data byte
  chk_ptr_step: assert property ( // (RL22)
    ack_end && phase_r == VMX_PH_DATA |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("pointer did not advance");

  // (RL11) unmapped write leaves registers alone
  chk_unmapped: assert property ( // (RL11)
    ack_end && phase_r == VMX_PH_DATA && ptr_r >= VMX_REG_COUNT
    |=> $stable(regs_r) ##1 $stable(regs_r))
    else $error("unmapped write changed a register");

  // (RL6) output 0 off after a SEL12 change means power down, no source
  chk_pdn_off: assert property ( // (RL6)
    $changed(regs_r[0]) && regs_r[0][3:0] == VMX_SEL_OFF
    |-> ctrl.pdn[0] && ctrl.src[0] == '0)
    else $error("off output not powered down");

  // main scenarios
  cov_data_write: cover property (wr_en ##[1:1000] wr_en);
  cov_unmapped:   cover property (ack_end && phase_r == VMX_PH_DATA && ptr_r >= VMX_REG_COUNT);
  cov_nack:       cover property (byte_end && phase_r == VMX_PH_ADDR && !addr_hit);
  cov_rep_start:  cover property (state_r == VMX_ST_RECV && phase_r == VMX_PH_DATA && start_det);
  cov_shared_src: cover property (ctrl.src[0] != '0 && ctrl.src[0] == ctrl.src[3]);

endmodule : vmx_ctrl

// ===== src/vmx_sync.sv
`timescale 1ns/1ps

// two flip-flop synchroniser, one lane per bit
module vmx_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // bus lines idle high: resetting to one avoids a false edge after reset
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : vmx_sync
